// ### core/cmg_guard.sv
// Top: CPU mode tracking and mode-based memory access gating
`timescale 1ns/1ps
module cmg_guard
  import cmg_pkg::*;
#(
  parameter int NUM_IRQ = 16
)(
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // Straps from fuses (asynchronous to mclk)
  input  wire logic                   test_fuse_live,
  // CPU side
  input  cmg_req_s                    cpu_req,
  input  wire logic                   cpu_jump,
  input  wire logic                   cpu_boot_done,
  input  wire logic                   cpu_to_user,
  input  wire logic [NUM_IRQ-1:0]     irq_req,
  // MMU user rights written by system-mode software
  input  wire logic                   uperm_we,
  input  wire logic [CMG_UPERM_W-1:0] uperm_wdata,
  // Arithmetic coprocessor side
  input  wire logic                   cop_valid,
  input  wire logic [CMG_AW-1:0]      cop_addr,
  // Verdicts
  output cmg_gnt_s                    cpu_gnt,
  output logic                        cop_grant,
  output logic                        cop_block,
  // Redirect of program flow
  output logic                        redir_valid,
  output logic [CMG_AW-1:0]           redir_addr,
  // Mode status
  output cmg_mode_e                   mode,
  output logic                        super_sys
);

  // Elaboration check: the interrupt index is five bits wide
  if (NUM_IRQ < 1 || NUM_IRQ > 32) begin : g_bad_irq
    $error("NUM_IRQ must be 1..32");
  end

  // Fuse sync; only the second stage is read
  logic fuse_s1_ff;
  logic fuse_s2_ff;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fuse_s1_ff <= 1'b0;
      fuse_s2_ff <= 1'b0;
    end else begin
      fuse_s1_ff <= test_fuse_live;
      fuse_s2_ff <= fuse_s1_ff;
    end
  end

  // Decoders
  cmg_region_e cpu_region;
  cmg_region_e cop_region;
  logic        fw_hit;
  logic        sc_hit;

  cmg_region_dec u_cpu_dec (
    .addr   (cpu_req.addr),
    .region (cpu_region)
  );

  cmg_region_dec u_cop_dec (
    .addr   (cop_addr),
    .region (cop_region)
  );

  cmg_vec_dec u_vec_dec (
    .addr   (cpu_req.addr),
    .fw_hit (fw_hit),
    .sc_hit (sc_hit)
  );

  // Mode state and user rights
  cmg_mode_e              mode_ff;
  cmg_mode_e              nxt_mode;
  logic [CMG_UPERM_W-1:0] uperm_ff;

  // Permission check per mode and region
  function automatic logic allowed(input cmg_mode_e   m,
                                   input cmg_region_e r,
                                   input logic [CMG_UPERM_W-1:0] up);
    logic ok;
    ok = 1'b0;
    unique case (m)
      CMG_TEST: ok = (r != CMG_R_NONE);
      CMG_BOOT, CMG_FIRM: begin
        ok = (r == CMG_R_TROM) || (r == CMG_R_EEMFG)
          || (r == CMG_R_EESUP) || (r == CMG_R_FWRAM)
          || (r == CMG_R_SFR);
      end
      CMG_SYS: begin
        ok = (r == CMG_R_AROM) || (r == CMG_R_EEAPP)
          || (r == CMG_R_GPRAM) || (r == CMG_R_CPRAM)
          || (r == CMG_R_SFR);
      end
      CMG_USER: begin
        unique case (r)
          CMG_R_AROM:  ok = up[CMG_UP_AROM];
          CMG_R_EEAPP: ok = up[CMG_UP_EE];
          CMG_R_GPRAM: ok = up[CMG_UP_GP];
          CMG_R_CPRAM: ok = up[CMG_UP_CP];
          default:     ok = 1'b0;
        endcase
      end
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  logic cpu_ok;
  logic jump_ok;
  assign cpu_ok  = allowed(mode_ff, cpu_region, uperm_ff);
  // A vector entry is itself the permitted way in, so it is not checked
  assign jump_ok = cpu_req.valid && cpu_jump && (fw_hit || sc_hit);

  // Lowest pending interrupt wins
  logic            irq_any;
  logic [4:0]      irq_idx;
  always_comb begin
    irq_any = 1'b0;
    irq_idx = 5'h00;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_req[i]) begin
        irq_any = 1'b1;
        irq_idx = 5'(i);
      end
    end
  end

  logic viol;
  assign viol = cpu_req.valid && !cpu_ok && !jump_ok;

  // Next mode: only vectors and the boot hand-off move upward
  always_comb begin
    nxt_mode = mode_ff;
    if (jump_ok && fw_hit) begin
      nxt_mode = CMG_FIRM;
    end else if (jump_ok && sc_hit) begin
      nxt_mode = CMG_SYS;
    end else if (mode_ff == CMG_BOOT && cpu_boot_done) begin
      nxt_mode = fuse_s2_ff ? CMG_TEST : CMG_SYS;
    end else if (mode_ff == CMG_SYS && cpu_to_user) begin
      nxt_mode = CMG_USER;
    end
  end

  // Mode register; reset always starts in boot
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_ff <= CMG_BOOT;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // MMU user rights, writable only from system mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      uperm_ff <= '0;
    end else if (uperm_we && mode_ff == CMG_SYS) begin
      uperm_ff <= uperm_wdata;
    end
  end

  // CPU verdict registered for timing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cpu_gnt <= '0;
    end else begin
      cpu_gnt.grant <= cpu_req.valid && (cpu_ok || jump_ok);
      cpu_gnt.block <= viol;
      cpu_gnt.addr  <= cpu_req.addr;
      cpu_gnt.write <= cpu_req.write && !viol;
    end
  end

  // Coprocessor: own RAM only, no MMU check
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cop_grant <= 1'b0;
      cop_block <= 1'b0;
    end else begin
      cop_grant <= cop_valid && (cop_region == CMG_R_CPRAM);
      cop_block <= cop_valid && (cop_region != CMG_R_CPRAM);
    end
  end

  // Redirect: violation exception beats interrupts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      redir_valid <= 1'b0;
      redir_addr  <= '0;
    end else if (viol) begin
      redir_valid <= 1'b1;
      redir_addr  <= 24'(CMG_XVEC_BASE
                         + {17'h0, CMG_EXC_ACCESS, 2'h0});
    end else if (irq_any) begin
      redir_valid <= 1'b1;
      redir_addr  <= 24'(CMG_IVEC_BASE + {17'h0, irq_idx, 2'h0});
    end else begin
      redir_valid <= 1'b0;
    end
  end

  // Status outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode      <= CMG_BOOT;
      super_sys <= 1'b1;
    end else begin
      mode      <= nxt_mode;
      super_sys <= (nxt_mode == CMG_BOOT) || (nxt_mode == CMG_TEST)
                || (nxt_mode == CMG_FIRM);
    end
  end

endmodule

// ### core/cmg_pkg.sv
// Package: modes, memory map, access request types for the mode guard
package cmg_pkg;

  // CPU modes, three of them forming the privileged super-system group
  typedef enum logic [2:0] {
    CMG_BOOT = 3'h0,
    CMG_TEST = 3'h1,
    CMG_FIRM = 3'h2,
    CMG_SYS  = 3'h3,
    CMG_USER = 3'h4
  } cmg_mode_e;

  // Memory regions found by the decoder
  typedef enum logic [3:0] {
    CMG_R_AROM   = 4'h0,
    CMG_R_TROM   = 4'h1,
    CMG_R_EEMFG  = 4'h2,
    CMG_R_EESUP  = 4'h3,
    CMG_R_EEAPP  = 4'h4,
    CMG_R_FWRAM  = 4'h5,
    CMG_R_GPRAM  = 4'h6,
    CMG_R_CPRAM  = 4'h7,
    CMG_R_SFR    = 4'h8,
    CMG_R_NONE   = 4'h9
  } cmg_region_e;

  localparam int CMG_AW = 24;

  // Memory map (byte addresses); sizes are the partition figures
  localparam logic [23:0] CMG_AROM_BASE  = 24'h000000;
  localparam logic [23:0] CMG_AROM_SIZE  = 24'h060000; // 384 KiB
  localparam logic [23:0] CMG_TROM_BASE  = 24'h060000;
  localparam logic [23:0] CMG_TROM_SIZE  = 24'h020000; // 128 KiB
  localparam logic [23:0] CMG_EE_BASE    = 24'h080000;
  localparam logic [23:0] CMG_EE_SIZE    = 24'h024000; // 144 KiB
  localparam logic [23:0] CMG_EEMFG_SIZE = 24'h000200; // 512 B
  localparam logic [23:0] CMG_EESUP_SIZE = 24'h000300; // 768 B
  localparam logic [23:0] CMG_RAM_BASE   = 24'h0C0000;
  localparam logic [23:0] CMG_FWRAM_SIZE = 24'h000200; // 512 B
  localparam logic [23:0] CMG_GPRAM_SIZE = 24'h001400; // 5.0 KiB
  localparam logic [23:0] CMG_CPRAM_SIZE = 24'h000A80; // 2.625 KiB
  localparam logic [23:0] CMG_SFR_BASE   = 24'h0D0000;
  localparam logic [23:0] CMG_SFR_SIZE   = 24'h001000;

  // Vector tables in application ROM
  localparam logic [23:0] CMG_FIRMWARE_ENTRY_VECTOR_BASE  = 24'h000100; // 8 entries
  localparam logic [23:0] CMG_SYSTEM_CALL_VECTOR_BASE  = 24'h000200; // 32 entries
  localparam logic [23:0] CMG_VEC_STRIDE = 24'h000004;
  localparam int          CMG_FIRMWARE_ENTRY_VECTOR_NUM   = 8;
  localparam int          CMG_SYSTEM_CALL_VECTOR_NUM   = 32;
  localparam logic [23:0] CMG_XVEC_BASE  = 24'h000000; // exceptions
  localparam logic [23:0] CMG_IVEC_BASE  = 24'h000040; // interrupts
  localparam logic [4:0]  CMG_EXC_ACCESS = 5'h01;      // access violation

  // MMU user-permission slots: one bit per user-gated region
  localparam int CMG_UPERM_W = 4;
  localparam int CMG_UP_AROM = 0;
  localparam int CMG_UP_EE   = 1;
  localparam int CMG_UP_GP   = 2;
  localparam int CMG_UP_CP   = 3;

  // CPU access request
  typedef struct packed {
    logic               valid;
    logic               fetch;
    logic               write;
    logic [CMG_AW-1:0]  addr;
  } cmg_req_s;

  // Guard verdict toward the memory system
  typedef struct packed {
    logic               grant;
    logic               block;
    logic [CMG_AW-1:0]  addr;
    logic               write;
  } cmg_gnt_s;

endpackage

// ### core/cmg_region_dec.sv
// Address decoder: maps a byte address onto a memory region
`timescale 1ns/1ps
module cmg_region_dec
  import cmg_pkg::*;
(
  // Address in
  input  wire logic [CMG_AW-1:0] addr,
  // Region out
  output cmg_region_e            region
);

  function automatic logic inside_rng(input logic [23:0] a,
                                      input logic [23:0] b,
                                      input logic [23:0] s);
    return (a >= b) && (a < 24'(b + s));
  endfunction

  // Firmware parts sit at the bottom of EEPROM and RAM
  always_comb begin
    region = CMG_R_NONE;
    if (inside_rng(addr, CMG_AROM_BASE, CMG_AROM_SIZE)) begin
      region = CMG_R_AROM;
    end else if (inside_rng(addr, CMG_TROM_BASE, CMG_TROM_SIZE)) begin
      region = CMG_R_TROM;
    end else if (inside_rng(addr, CMG_EE_BASE, CMG_EEMFG_SIZE)) begin
      region = CMG_R_EEMFG;
    end else if (inside_rng(addr, 24'(CMG_EE_BASE + CMG_EEMFG_SIZE),
                            CMG_EESUP_SIZE)) begin
      region = CMG_R_EESUP;
    end else if (inside_rng(addr, CMG_EE_BASE, CMG_EE_SIZE)) begin
      region = CMG_R_EEAPP;
    end else if (inside_rng(addr, CMG_RAM_BASE, CMG_FWRAM_SIZE)) begin
      region = CMG_R_FWRAM;
    end else if (inside_rng(addr, 24'(CMG_RAM_BASE + CMG_FWRAM_SIZE),
                            CMG_GPRAM_SIZE)) begin
      region = CMG_R_GPRAM;
    end else if (inside_rng(addr, 24'(CMG_RAM_BASE + CMG_FWRAM_SIZE
                                      + CMG_GPRAM_SIZE),
                            CMG_CPRAM_SIZE)) begin
      region = CMG_R_CPRAM;
    end else if (inside_rng(addr, CMG_SFR_BASE, CMG_SFR_SIZE)) begin
      region = CMG_R_SFR;
    end
  end

endmodule

// ### core/cmg_vec_dec.sv
// Vector decoder: recognises firmware-entry and system-call targets
`timescale 1ns/1ps
module cmg_vec_dec
  import cmg_pkg::*;
(
  // Jump target
  input  wire logic [CMG_AW-1:0] addr,
  // Hits
  output logic                   fw_hit,
  output logic                   sc_hit
);

  function automatic logic vec_hit(input logic [23:0] a,
                                   input logic [23:0] b,
                                   input int          n);
    logic [23:0] off;
    off = 24'(a - b);
    return (a >= b) && (off[1:0] == 2'h0)
           && (off < 24'(n * CMG_VEC_STRIDE));
  endfunction

  assign fw_hit = vec_hit(addr, CMG_FIRMWARE_ENTRY_VECTOR_BASE, CMG_FIRMWARE_ENTRY_VECTOR_NUM);
  assign sc_hit = vec_hit(addr, CMG_SYSTEM_CALL_VECTOR_BASE, CMG_SYSTEM_CALL_VECTOR_NUM);

endmodule

// ### test/cmg_guard_checker.sv
// Checker: mode and access properties seen at the guard ports
`timescale 1ns/1ps
module cmg_guard_checker
  import cmg_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst,
  // CPU and coprocessor requests
  input cmg_req_s               cpu_req,
  input wire logic              cpu_jump,
  input wire logic              cpu_boot_done,
  input wire logic              cpu_to_user,
  input wire logic              cop_valid,
  input wire logic [CMG_AW-1:0] cop_addr,
  // Guard outputs
  input cmg_gnt_s               cpu_gnt,
  input wire logic              cop_grant,
  input wire logic              redir_valid,
  input wire logic [CMG_AW-1:0] redir_addr,
  input cmg_mode_e              mode,
  input wire logic              super_sys
);
  logic jv;
  logic fv;
  logic sv;
  // Aligned jumps into the firmware and system-call tables
  assign jv = cpu_jump && cpu_req.valid && cpu_req.addr[1:0] == 2'h0;
  assign fv = jv && cpu_req.addr[23:5] == 19'h8;
  assign sv = jv && cpu_req.addr[23:7] == 17'h4;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_answer;
    cpu_req.valid |=> cpu_gnt.grant != cpu_gnt.block;
  endproperty
  a_answer: assert property (p_answer) else $error("no single verdict");
  property p_redir;
    cpu_gnt.block |-> redir_valid && redir_addr == 24'h4 && !cpu_gnt.write;
  endproperty
  a_redir: assert property (p_redir) else $error("bad block redirect");
  property p_super;
    super_sys == (mode inside {CMG_BOOT, CMG_TEST, CMG_FIRM});
  endproperty
  a_super: assert property (p_super) else $error("super flag wrong");
  property p_firmware_entry_vector;
    fv |=> mode == CMG_FIRM && cpu_gnt.grant;
  endproperty
  a_firmware_entry_vector: assert property (p_firmware_entry_vector) else $error("no firmware entry");
  property p_system_call_vector;
    sv |=> mode == CMG_SYS && cpu_gnt.grant;
  endproperty
  a_system_call_vector: assert property (p_system_call_vector) else $error("no system entry");
  property p_boot;
    mode inside {CMG_BOOT, CMG_FIRM} && cpu_req.valid && !cpu_jump
      && cpu_req.addr < 24'h060000 |=> cpu_gnt.block;
  endproperty
  a_boot: assert property (p_boot) else $error("app rom reached");
  property p_cop;
    cop_valid |=> cop_grant
      == ($past(cop_addr) inside {[24'hC1600:24'hC207F]});
  endproperty
  a_cop: assert property (p_cop) else $error("coproc verdict");
  property p_hold;
    $changed(mode) |-> $past(jv || cpu_boot_done || cpu_to_user);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved alone");
endmodule

bind cmg_guard cmg_guard_checker u_chk (
  .mclk(mclk), .rst(rst), .cpu_req(cpu_req), .cpu_jump(cpu_jump),
  .cpu_boot_done(cpu_boot_done), .cpu_to_user(cpu_to_user),
  .cop_valid(cop_valid), .cop_addr(cop_addr), .cpu_gnt(cpu_gnt),
  .cop_grant(cop_grant), .redir_valid(redir_valid),
  .redir_addr(redir_addr), .mode(mode), .super_sys(super_sys)
);

// ### test/cmg_cpu_model.sv
// CPU core model: turns bench commands into guard requests
`timescale 1ns/1ps
module cmg_cpu_model
  import cmg_pkg::*;
(
  // Clock
  input wire logic              mclk,
  // Bench commands
  input wire logic              go,
  input wire logic              jump,
  input wire logic              write,
  input wire logic [CMG_AW-1:0] addr,
  // Request to the guard
  output cmg_req_s              cpu_req,
  output logic                  cpu_jump
);
  logic [CMG_AW-1:0] junk_ff = 24'h5A5A5A;
  // Idle address flips every cycle so stale values never look valid
  always_ff @(posedge mclk) begin
    junk_ff <= ~junk_ff;
  end
  // Vector jumps happen only when the bench asks for one
  assign cpu_jump = go && jump;
  assign cpu_req = {go, jump, go && write, go ? addr : junk_ff};
endmodule

// ### test/cmg_guard_test.sv
// Testbench: mode switching and access gating of the guard
`timescale 1ns/1ps
module cmg_guard_test;
  import cmg_pkg::*;
  logic mclk = 1'h0, rst = 1'h1, fuse = 1'h0, go = 1'h0, jump = 1'h0;
  logic bd = 1'h0, tu = 1'h0, pwe = 1'h0, cv = 1'h0, wr = 1'h0;
  logic [23:0] addr = 24'h0, caddr = 24'h0, redir_addr;
  logic [15:0] irq = 16'h0;
  logic [3:0] pw = 4'h0;
  logic cop_grant, cop_block, redir_valid, super_sys, cpu_jump;
  cmg_req_s cpu_req;
  cmg_gnt_s cpu_gnt;
  cmg_mode_e mode;
  int num_errors = 0, check_count = 0;

  cmg_cpu_model u_cpu (.mclk(mclk), .go(go), .jump(jump), .write(wr),
    .addr(addr), .cpu_req(cpu_req), .cpu_jump(cpu_jump));
  cmg_guard #(.NUM_IRQ(16)) uut (.mclk(mclk), .rst(rst),
    .test_fuse_live(fuse), .cpu_req(cpu_req), .cpu_jump(cpu_jump),
    .cpu_boot_done(bd), .cpu_to_user(tu), .irq_req(irq),
    .uperm_we(pwe), .uperm_wdata(pw), .cop_valid(cv), .cop_addr(caddr),
    .cpu_gnt(cpu_gnt), .cop_grant(cop_grant), .cop_block(cop_block),
    .redir_valid(redir_valid), .redir_addr(redir_addr), .mode(mode),
    .super_sys(super_sys));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [23:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic do_reset(input logic f);
    fuse = f;
    rst = 1'h1;
    repeat (4) @(negedge mclk);
    chk("reset_mode", {21'h0, CMG_BOOT}, {21'h0, mode});
    rst = 1'h0;
    repeat (3) @(negedge mclk);
  endtask

  task automatic acc(input logic [23:0] a, input logic j, g);
    @(negedge mclk);
    go = 1'h1;
    addr = a;
    jump = j;
    wr = !j;
    @(negedge mclk);
    go = 1'h0;
    jump = 1'h0;
    wr = 1'h0;
    chk("verdict", {22'h0, g, !g},
        {22'h0, cpu_gnt.grant, cpu_gnt.block});
    chk("gnt_addr", a, cpu_gnt.addr);
    chk("gnt_write", {23'h0, g && !j}, {23'h0, cpu_gnt.write});
    chk("redir", {23'h0, !g}, {23'h0, redir_valid});
    if (!g) chk("redir_addr", 24'h4, redir_addr);
  endtask

  task automatic step(input logic b, u, input cmg_mode_e m);
    @(negedge mclk);
    bd = b;
    tu = u;
    @(negedge mclk);
    bd = 1'h0;
    tu = 1'h0;
    chk("mode", {21'h0, m}, {21'h0, mode});
    chk("super", {23'h0, m < CMG_SYS}, {23'h0, super_sys});
  endtask

  task automatic sweep(input logic [23:0] t [12], input logic [11:0] g);
    for (int i = 0; i < 12; i++) acc(t[i], 1'h0, g[i]);
  endtask

  task automatic perm(input logic [3:0] v);
    @(negedge mclk);
    pwe = 1'h1;
    pw = v;
    @(negedge mclk);
    pwe = 1'h0;
  endtask

  task automatic cop(input logic [23:0] a, input logic g);
    @(negedge mclk);
    cv = 1'h1;
    caddr = a;
    @(negedge mclk);
    cv = 1'h0;
    chk("cop", {22'h0, g, !g}, {22'h0, cop_grant, cop_block});
  endtask

  task automatic t_test();
    do_reset(1'h1);
    step(1'h1, 1'h0, CMG_TEST);
    sweep('{24'h0, 24'h5FFFC, 24'h60000, 24'h80000, 24'h80200, 24'h80500,
      24'hA3FFF, 24'hC0000, 24'hC0200, 24'hC1600, 24'hD0000, 24'hA4000},
      12'h7FF);
    $display("test mode sweep done");
  endtask

  task automatic t_boot();
    do_reset(1'h0);
    sweep('{24'h60000, 24'h7FFFC, 24'h80000, 24'h801FF, 24'h80200,
      24'h804FF, 24'h80500, 24'hC0000, 24'hC01FF, 24'hC0200, 24'h5FFFC,
      24'hC1600}, 12'h1BF);
    step(1'h1, 1'h0, CMG_SYS);
    sweep('{24'h0, 24'h5FFFC, 24'h60000, 24'h80000, 24'h804FF, 24'h80500,
      24'hA3FFF, 24'hC01FF, 24'hC0200, 24'hC207F, 24'hD0FFC, 24'hA4000},
      12'h763);
    $display("boot and system sweep done");
  endtask

  task automatic t_vec();
    for (int k = 0; k < 8; k++) begin
      acc(24'h100 + 24'(4 * k), 1'h1, 1'h1);
      chk("firmware_entry_vector_mode", {21'h0, CMG_FIRM}, {21'h0, mode});
      acc(24'h200 + 24'(16 * k + 12), 1'h1, 1'h1);
      chk("system_call_vector_mode", {21'h0, CMG_SYS}, {21'h0, mode});
    end
    $display("vector jumps done");
  endtask

  task automatic t_user();
    perm(4'h0);
    step(1'h0, 1'h1, CMG_USER);
    acc(24'h1000, 1'h0, 1'h0);
    acc(24'hD0000, 1'h0, 1'h0);
    cop(24'hC1600, 1'h1);
    cop(24'hC207F, 1'h1);
    cop(24'hC15FF, 1'h0);
    cop(24'hC2080, 1'h0);
    step(1'h1, 1'h0, CMG_USER);
    perm(4'hF);
    acc(24'h1000, 1'h0, 1'h0);
    acc(24'h27C, 1'h1, 1'h1);
    perm(4'h5);
    step(1'h0, 1'h1, CMG_USER);
    acc(24'h1000, 1'h0, 1'h1);
    acc(24'hC0200, 1'h0, 1'h1);
    acc(24'h80500, 1'h0, 1'h0);
    acc(24'h200, 1'h1, 1'h1);
    $display("user rights done");
  endtask

  task automatic t_irq();
    @(negedge mclk);
    irq = 16'h0008;
    @(negedge mclk);
    chk("irq3", 24'h4C, redir_valid ? redir_addr : 24'h0);
    irq = 16'h0009;
    @(negedge mclk);
    chk("irq0", 24'h40, redir_valid ? redir_addr : 24'h0);
    acc(24'h60000, 1'h0, 1'h0);
    irq = 16'h0;
    $display("interrupt vectors done");
  endtask

  // Watchdog sized well above the under two hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    t_test();
    t_boot();
    t_vec();
    t_user();
    t_irq();
    close_out();
  end
endmodule
